// [core/svmc_ctrl.v]
// Two supply voltage monitors: control bits, detect flags and request outputs
`timescale 1ns/1ps
`include "svmc_map.vh"
// Overview of operation
// (R1) Software sets monitor 1 falling direction for reset
// (R2) No interrupt while enables are both off
// (R3) Late crossing still sets monitor 1 flag
// (R4) Writing 0 clears monitor 1 detect flag
// (R5) Software disables monitor 1 filter for stop
// (R6) Monitor 1 reset sets its source flag
// (R7) Detector 2 compares only when both enabled
// (R8) Live detector 2 level shown as status
// (R9) Monitor 2 action select: interrupt or reset
// (R10) Filter control 0 filters, 1 bypasses
// (R11) Software waits three sampling ticks before enabling
// (R12) Software sets monitor 2 falling for reset
// (R13) Control fields load together while disabled
// (R14) Late crossing still sets monitor 2 flag
// (R15) Monitor 2 reset sets its source flag
// (R16) Monitor interrupts are non-maskable
// (R17) Shared vector; flags cleared by writing 0
// (R18) Filter issues after two equal samples
// (R19) Sampling clock is oscillator over 1/2/4/8
// (R20) Filtered monitor 2 ignores direction select
// (R21) Detect flags sticky until written 0
// (R22) Request only with both enables set
module svmc_ctrl (
  input  wire       clk,                    // System clock, 100 MHz
  input  wire       rst_n,                  // Asynchronous reset, active low
  input  wire       lowspeed_osc_clock,     // Low-speed oscillator, asynchronous
  input  wire       lowspeed_osc_stop,      // 1 stops the low-speed oscillator
  input  wire       mon12_common_en,        // Common enable for monitors 1 and 2
  input  wire       det1_enable,            // Detector 1 enable
  input  wire       det2_enable,            // Detector 2 enable
  input  wire       cmp1_above,             // Comparator: supply above threshold_one
  input  wire       cmp2_above,             // Comparator: supply above threshold_two
  input  wire       mon1_ctrl_we,           // Write strobe for monitor 1 control
  input  wire       mon1_irq_reset_en_wr,   // Write data: interrupt/reset enable
  input  wire       mon1_filter_off_wr,     // Write data: filter bypass
  input  wire       mon1_action_sel_wr,     // Write data: 0 interrupt, 1 reset
  input  wire       mon1_direction_sel_wr,  // Write data: 1 falling, 0 rising
  input  wire [1:0] mon1_sample_div_wr,     // Write data: sampling divide
  input  wire       mon1_flag_we,           // Write strobe for monitor 1 flag
  input  wire       mon1_flag_wr,           // Flag write data; only 0 acts
  input  wire       mon2_ctrl_we,           // Write strobe for monitor 2 control
  input  wire       mon2_irq_reset_en_wr,   // Write data: interrupt/reset enable
  input  wire       mon2_filter_off_wr,     // Write data: filter bypass
  input  wire       mon2_action_sel_wr,     // Write data: 0 interrupt, 1 reset
  input  wire       mon2_direction_sel_wr,  // Write data: 1 falling, 0 rising
  input  wire [1:0] mon2_sample_div_wr,     // Write data: sampling divide
  input  wire       mon2_flag_we,           // Write strobe for monitor 2 flag
  input  wire       mon2_flag_wr,           // Flag write data; only 0 acts
  input  wire       rst_flag_clr,           // Pulse clears both reset-source flags
  output reg        mon1_irq_reset_en,      // Monitor 1 enable readback
  output reg        mon1_filter_off,        // Monitor 1 filter bypass readback
  output reg        mon1_action_sel,        // Monitor 1 action readback
  output reg        mon1_direction_sel,     // Monitor 1 direction readback
  output reg        mon2_irq_reset_en,      // Monitor 2 enable readback
  output reg        mon2_filter_off,        // Monitor 2 filter bypass readback
  output reg        mon2_action_sel,        // Monitor 2 action readback
  output reg        mon2_direction_sel,     // Monitor 2 direction readback
  output reg        mon2_sample_div_lo,     // Monitor 2 divide bit 0 readback
  output reg        mon2_sample_div_hi,     // Monitor 2 divide bit 1 readback
  output reg        mon1_detect_flag,       // Monitor 1 sticky detect
  output reg        mon2_detect_flag,       // Monitor 2 sticky detect
  output reg        det1_level_status,      // Live detector 1 level
  output reg        det2_level_status,      // Live detector 2 level
  output reg        nmi_req,                // Non-maskable interrupt pulse
  output reg        mon_reset_req,          // Internal reset request pulse
  output reg        mon1_reset_source_flag, // Monitor 1 caused a reset
  output reg        mon2_reset_source_flag  // Monitor 2 caused a reset
);
  reg  [1:0] mon1_div;
  reg  [`SVMC_OSC_STAGES-1:0] osc_sync;
  reg        osc_level;
  reg        osc_prev;
  reg        lvl1_prev;
  reg        lvl2_prev;
  wire       osc_tick;
  wire       run1;
  wire       run2;
  wire       lvl1;
  wire       lvl2;
  wire       raw1;
  wire       raw2;
  wire       arm1;
  wire       arm2;
  wire       hit1;
  wire       hit2;
  wire       next_flag1;
  wire       next_flag2;
  wire       fire_int1;
  wire       fire_rst1;
  wire       fire_int2;
  wire       fire_rst2;
  wire [1:0] run_vec;
  wire [1:0] settled;
  genvar     g;

  // Crossing matches the direction select; filtered monitor 2 takes both
  function crossing;
    input prev;
    input now;
    input falling;
    input any_dir;
    begin
      crossing = (prev != now) && (any_dir || (falling ? !now : now));
    end
  endfunction

  assign run1 = mon12_common_en && det1_enable;
  assign run2 = mon12_common_en && det2_enable; // (R7)

  // Fresh detector output is not trusted until it has settled after enable;
  // otherwise the level step at power-up would count as a crossing
  assign run_vec = {run2, run1};
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_settle
      reg [`SVMC_SETTLE_W-1:0] settle_cnt;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          settle_cnt <= `SVMC_SETTLE_CYCLES;
        end else if (!run_vec[g]) begin
          settle_cnt <= `SVMC_SETTLE_CYCLES;
        end else if (settle_cnt != {`SVMC_SETTLE_W{1'b0}}) begin
          settle_cnt <= settle_cnt - {{(`SVMC_SETTLE_W-1){1'b0}}, 1'b1};
        end
      end
      assign settled[g] = (settle_cnt == {`SVMC_SETTLE_W{1'b0}}); // (R8)
    end
  endgenerate

  // Rising oscillator edges become one-cycle ticks; a stopped oscillator gives none
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_sync  <= {`SVMC_OSC_STAGES{1'b0}};
      osc_level <= 1'b0;
      osc_prev  <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[`SVMC_OSC_STAGES-2:0], lowspeed_osc_clock};
      if (osc_sync[1] == osc_sync[2]) begin
        osc_level <= osc_sync[2];
      end
      osc_prev <= osc_level;
    end
  end
  assign osc_tick = osc_level && !osc_prev && !lowspeed_osc_stop;

  svmc_filter u_filt1 (
    .clk        (clk),
    .rst_n      (rst_n),
    .cmp_in     (cmp1_above),
    .osc_tick   (osc_tick),
    .div_sel    (mon1_div),
    .filter_off (mon1_filter_off),
    .run        (run1),
    .level      (lvl1),
    .cmp_sync   (raw1)
  );

  svmc_filter u_filt2 (
    .clk        (clk),
    .rst_n      (rst_n),
    .cmp_in     (cmp2_above),
    .osc_tick   (osc_tick),
    .div_sel    ({mon2_sample_div_hi, mon2_sample_div_lo}),
    .filter_off (mon2_filter_off),
    .run        (run2),
    .level      (lvl2),
    .cmp_sync   (raw2)
  );

  // Control fields; select fields change only while the monitor is disabled
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon1_irq_reset_en  <= `SVMC_RST_CTRL;
      mon1_filter_off    <= `SVMC_RST_FILTER_OFF;
      mon1_action_sel    <= `SVMC_RST_CTRL;
      mon1_direction_sel <= `SVMC_RST_CTRL;
      mon1_div           <= `SVMC_RST_DIV;
      mon2_irq_reset_en  <= `SVMC_RST_CTRL;
      mon2_filter_off    <= `SVMC_RST_FILTER_OFF;
      mon2_action_sel    <= `SVMC_RST_CTRL;
      mon2_direction_sel <= `SVMC_RST_CTRL;
      mon2_sample_div_lo <= `SVMC_RST_CTRL;
      mon2_sample_div_hi <= `SVMC_RST_CTRL;
    end else begin
      if (mon1_ctrl_we) begin
        mon1_irq_reset_en <= mon1_irq_reset_en_wr;
        if (!mon1_irq_reset_en) begin
          mon1_filter_off    <= mon1_filter_off_wr; // (R13)
          mon1_action_sel    <= mon1_action_sel_wr;
          mon1_direction_sel <= mon1_direction_sel_wr;
          mon1_div           <= mon1_sample_div_wr;
        end
      end
      if (mon2_ctrl_we) begin
        mon2_irq_reset_en <= mon2_irq_reset_en_wr;
        if (!mon2_irq_reset_en) begin
          mon2_filter_off    <= mon2_filter_off_wr; // (R13)
          mon2_action_sel    <= mon2_action_sel_wr;
          mon2_direction_sel <= mon2_direction_sel_wr;
          mon2_sample_div_lo <= mon2_sample_div_wr[0];
          mon2_sample_div_hi <= mon2_sample_div_wr[1];
        end
      end
    end
  end

  // A level step seen once the running detector has settled counts as a crossing if its direction passes the check above
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl1_prev <= 1'b0;
      lvl2_prev <= 1'b0;
    end else begin
      lvl1_prev <= lvl1;
      lvl2_prev <= lvl2;
    end
  end

  // Armed only once the detector and the request enable are both on
  assign arm1 = run1 && mon1_irq_reset_en; // (R22)
  assign arm2 = run2 && mon2_irq_reset_en; // (R22)
  // Flags also catch crossings while the enable is still off
  // Limitation: a filtered monitor may still report one edge after enable,
  // since its level only moves after three samples; software clears it
  assign hit1 = run1 && settled[0] &&
                crossing(lvl1_prev, lvl1, mon1_direction_sel, 1'b0); // (R3)
  assign hit2 = run2 && settled[1] &&
                crossing(lvl2_prev, lvl2, mon2_direction_sel,
                         !mon2_filter_off); // (R20) (R14)

  // Set wins over a software clear in the same cycle
  assign next_flag1 = hit1 ? 1'b1 :
                      ((mon1_flag_we && !mon1_flag_wr) ? 1'b0 : mon1_detect_flag); // (R4) (R21)
  assign next_flag2 = hit2 ? 1'b1 :
                      ((mon2_flag_we && !mon2_flag_wr) ? 1'b0 : mon2_detect_flag); // (R17) (R21)

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon1_detect_flag  <= 1'b0;
      mon2_detect_flag  <= 1'b0;
      det1_level_status <= 1'b0;
      det2_level_status <= 1'b0;
    end else begin
      mon1_detect_flag  <= next_flag1;
      mon2_detect_flag  <= next_flag2;
      det1_level_status <= run1 && raw1;
      det2_level_status <= run2 && raw2; // (R8)
    end
  end

  // Each request decoded once, shared by the pulse and the source flag
  assign fire_int1 = hit1 && arm1 && !mon1_action_sel; // (R9)
  assign fire_rst1 = hit1 && arm1 && mon1_action_sel;
  assign fire_int2 = hit2 && arm2 && !mon2_action_sel;
  assign fire_rst2 = hit2 && arm2 && mon2_action_sel;

  // Requests: one shared non-maskable line, no mask exists to stop it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_req                <= 1'b0;
      mon_reset_req          <= 1'b0;
      mon1_reset_source_flag <= 1'b0;
      mon2_reset_source_flag <= 1'b0;
    end else begin
      nmi_req       <= fire_int1 || fire_int2; // (R2) (R16) (R17)
      mon_reset_req <= fire_rst1 || fire_rst2; // (R9)
      if (fire_rst1) begin
        mon1_reset_source_flag <= 1'b1; // (R6)
      end else if (rst_flag_clr) begin
        mon1_reset_source_flag <= 1'b0;
      end
      if (fire_rst2) begin
        mon2_reset_source_flag <= 1'b1; // (R15)
      end else if (rst_flag_clr) begin
        mon2_reset_source_flag <= 1'b0;
      end
    end
  end
endmodule // svmc_ctrl

// [core/svmc_map.vh]
// Constants for the supply voltage monitor control block
`ifndef SVMC_MAP_VH
`define SVMC_MAP_VH
`define SVMC_RST_CTRL       1'b0
`define SVMC_RST_FILTER_OFF 1'b1
`define SVMC_RST_DIV        2'h0
`define SVMC_FILT_SAMPLES   2'h2
`define SVMC_OSC_STAGES     3
`define SVMC_SETTLE_W       4
`define SVMC_SETTLE_CYCLES  4'h8
`endif

// [core/svmc_filter.v]
// Per-monitor comparator synchroniser, sampling-tick divider and digital filter
`timescale 1ns/1ps
`include "svmc_map.vh"
module svmc_filter (
  input  wire       clk,          // System clock
  input  wire       rst_n,        // Asynchronous reset, active low
  input  wire       cmp_in,       // Raw comparator level, asynchronous
  input  wire       osc_tick,     // One pulse per low-speed oscillator cycle
  input  wire [1:0] div_sel,      // Sampling divide: 1, 2, 4 or 8
  input  wire       filter_off,   // 1 bypasses the filter
  input  wire       run,          // Detector powered and enabled
  output reg        level,        // Qualified comparator level
  output wire       cmp_sync      // Synchronised raw level
);
  reg  [2:0] sync;
  reg  [2:0] div_cnt;
  reg        samp_a;
  reg        samp_b;
  reg        sync_level;
  wire [2:0] div_mask;
  wire       samp_tick;

  // Three stages; the level moves only when stages two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync       <= 3'h0;
      sync_level <= 1'b0;
    end else begin
      sync <= {sync[1:0], cmp_in};
      if (sync[1] == sync[2]) begin
        sync_level <= sync[2];
      end
    end
  end
  assign cmp_sync = sync_level;

  assign div_mask  = (3'h1 << div_sel) - 3'h1;
  assign samp_tick = osc_tick && ((div_cnt & div_mask) == 3'h0); // (R19)

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 3'h0;
    end else if (osc_tick) begin
      div_cnt <= div_cnt + 3'h1; // (R19)
    end
  end

  // Two equal samples, then the level follows at the next tick
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_a <= 1'b0;
      samp_b <= 1'b0;
      level  <= 1'b0;
    end else if (!run) begin
      samp_a <= 1'b0;
      samp_b <= 1'b0;
      level  <= 1'b0;
    end else if (filter_off) begin
      samp_a <= sync_level;
      samp_b <= sync_level;
      level  <= sync_level; // (R10)
    end else if (samp_tick) begin
      samp_a <= sync_level;
      samp_b <= samp_a;
      if (samp_a == samp_b) begin
        level <= samp_b; // (R18)
      end
    end
  end
endmodule // svmc_filter

// [test/svmc_ctrl_sva.sv]
// Checker for the supply monitor control block
`timescale 1ns/1ps
module svmc_ctrl_sva (
  input logic clk,                    // clock
  input logic rst_n,                  // reset
  input logic mon12_common_en,        // common enable
  input logic det2_enable,            // detector 2 enable
  input logic mon1_ctrl_we,           // ctrl strobe
  input logic mon1_flag_we,           // flag strobe
  input logic mon1_flag_wr,           // flag data
  input logic mon2_flag_we,           // flag strobe
  input logic mon2_flag_wr,           // flag data
  input logic mon1_irq_reset_en,      // enable
  input logic mon1_filter_off,        // bypass
  input logic mon1_action_sel,        // action
  input logic mon2_irq_reset_en,      // enable
  input logic mon2_action_sel,        // action
  input logic mon1_detect_flag,       // flag
  input logic mon2_detect_flag,       // flag
  input logic det2_level_status,      // level
  input logic nmi_req,                // interrupt
  input logic mon_reset_req,          // reset request
  input logic mon1_reset_source_flag, // source
  input logic mon2_reset_source_flag  // source
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_nmi_en;
    nmi_req |-> $past(mon1_irq_reset_en && !mon1_action_sel) ||
      $past(mon2_irq_reset_en && !mon2_action_sel);
  endproperty
  a_nmi_en: assert property (p_nmi_en) else $error("interrupt without enable");
  property p_rst_en;
    mon_reset_req |-> $past(mon1_irq_reset_en && mon1_action_sel) ||
      $past(mon2_irq_reset_en && mon2_action_sel);
  endproperty
  a_rst_en: assert property (p_rst_en) else $error("reset without select");
  property p_src;
    mon_reset_req |-> ##[0:2] (mon1_reset_source_flag || mon2_reset_source_flag);
  endproperty
  a_src: assert property (p_src) else $error("source flag missing");
  property p_clr1;
    mon1_flag_we && !mon1_flag_wr |=> !mon1_detect_flag;
  endproperty
  a_clr1: assert property (p_clr1) else $error("flag not cleared");
  property p_hold1;
    mon1_detect_flag && !(mon1_flag_we && !mon1_flag_wr) |=> mon1_detect_flag;
  endproperty
  a_hold1: assert property (p_hold1) else $error("flag 1 dropped");
  property p_hold2;
    mon2_detect_flag && !(mon2_flag_we && !mon2_flag_wr) |=> mon2_detect_flag;
  endproperty
  a_hold2: assert property (p_hold2) else $error("flag 2 dropped");
  property p_lock1;
    mon1_irq_reset_en && mon1_ctrl_we |=> $stable(mon1_filter_off) && $stable(mon1_action_sel);
  endproperty
  a_lock1: assert property (p_lock1) else $error("locked field changed");
  property p_det2;
    (!mon12_common_en || !det2_enable) [*4] |-> !det2_level_status;
  endproperty
  a_det2: assert property (p_det2) else $error("status while off");
  property p_pulse;
    nmi_req |=> !nmi_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("interrupt not a pulse");
  c_nmi: cover property (nmi_req);
  c_rst: cover property (mon_reset_req);
  c_src2: cover property (mon2_reset_source_flag);
endmodule // svmc_ctrl_sva
bind svmc_ctrl svmc_ctrl_sva u_sva (.*);

// [test/tb.sv]
// Self-checking bench for the supply monitor control block
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, lowspeed_osc_clock, lowspeed_osc_stop, mon12_common_en;
  logic det1_enable, det2_enable, cmp1_above, cmp2_above, rst_flag_clr;
  logic mon1_ctrl_we, mon1_irq_reset_en_wr, mon1_filter_off_wr, mon1_action_sel_wr;
  logic mon1_direction_sel_wr, mon1_flag_we, mon1_flag_wr, mon2_ctrl_we;
  logic mon2_irq_reset_en_wr, mon2_filter_off_wr, mon2_action_sel_wr;
  logic mon2_direction_sel_wr, mon2_flag_we, mon2_flag_wr;
  logic [1:0] mon1_sample_div_wr, mon2_sample_div_wr;
  logic mon1_irq_reset_en, mon1_filter_off, mon1_action_sel, mon1_direction_sel;
  logic mon2_irq_reset_en, mon2_filter_off, mon2_action_sel, mon2_direction_sel;
  logic mon2_sample_div_lo, mon2_sample_div_hi, mon1_detect_flag, mon2_detect_flag;
  logic det1_level_status, det2_level_status, nmi_req, mon_reset_req;
  logic mon1_reset_source_flag, mon2_reset_source_flag;
  int miscompares = 0, check_count = 0, cycles = 0, nmi_seen, rst_seen;
  svmc_ctrl dut (.*);
  always #5 clk = ~clk;
  always #40 lowspeed_osc_clock = ~lowspeed_osc_clock;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ctrl(input int n, input logic en, fo, act, dir, input logic [1:0] dv);
    if (n == 1) {mon1_irq_reset_en_wr, mon1_filter_off_wr, mon1_action_sel_wr,
      mon1_direction_sel_wr, mon1_sample_div_wr, mon1_ctrl_we} = {en, fo, act, dir, dv, 1'b1};
    else {mon2_irq_reset_en_wr, mon2_filter_off_wr, mon2_action_sel_wr,
      mon2_direction_sel_wr, mon2_sample_div_wr, mon2_ctrl_we} = {en, fo, act, dir, dv, 1'b1};
    step(1);
    {mon1_ctrl_we, mon2_ctrl_we} = 2'h0;
    step(1);
  endtask
  task automatic flag(input int n, input logic v);
    if (n == 1) {mon1_flag_we, mon1_flag_wr} = {1'b1, v};
    else {mon2_flag_we, mon2_flag_wr} = {1'b1, v};
    step(1);
    {mon1_flag_we, mon2_flag_we} = 2'h0;
    step(1);
  endtask
  // Counts request pulses; each stands one cycle
  task automatic watch(input int n);
    nmi_seen = 0;
    rst_seen = 0;
    repeat (n) begin
      step(1);
      nmi_seen += (nmi_req === 1'b1);
      rst_seen += (mon_reset_req === 1'b1);
    end
  endtask
  task automatic chk(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    {clk, lowspeed_osc_clock, rst_n, lowspeed_osc_stop, rst_flag_clr} = 5'h00;
    {mon12_common_en, det1_enable, det2_enable, mon1_ctrl_we, mon2_ctrl_we} = 5'h00;
    {mon1_flag_we, mon2_flag_we, mon1_flag_wr, mon2_flag_wr} = 4'h0;
    {mon1_irq_reset_en_wr, mon1_filter_off_wr, mon1_action_sel_wr} = 3'h0;
    {mon2_irq_reset_en_wr, mon2_filter_off_wr, mon2_action_sel_wr} = 3'h0;
    {mon1_direction_sel_wr, mon2_direction_sel_wr} = 2'h0;
    {mon1_sample_div_wr, mon2_sample_div_wr, cmp1_above, cmp2_above} = 6'h03;
    step(3);
    rst_n = 1;
    chk({mon1_filter_off, mon2_filter_off, mon1_irq_reset_en, mon1_detect_flag}, 8'h0C);
    {mon12_common_en, det1_enable} = 2'h3;
    ctrl(1, 0, 1, 0, 1, 2'h0);
    watch(10);
    cmp1_above = 0;
    watch(12);
    chk(nmi_seen, 0);
    chk(mon1_detect_flag, 1);
    flag(1, 1);
    chk(mon1_detect_flag, 1);
    flag(1, 0);
    chk(mon1_detect_flag, 0);
    ctrl(1, 1, 1, 0, 1, 2'h0);
    ctrl(1, 1, 0, 1, 0, 2'h3);
    chk({mon1_filter_off, mon1_action_sel, mon1_direction_sel}, 8'h05);
    cmp1_above = 1;
    watch(12);
    chk(nmi_seen + mon1_detect_flag, 0);
    cmp1_above = 0;
    watch(12);
    chk(nmi_seen, 1);
    chk(mon1_detect_flag, 1);
    flag(1, 0);
    // Disable first so the reset selection is accepted
    ctrl(1, 0, 1, 1, 1, 2'h0);
    ctrl(1, 1, 1, 1, 1, 2'h0);
    cmp1_above = 1;
    watch(12);
    cmp1_above = 0;
    watch(12);
    chk(rst_seen, 1);
    chk(mon1_reset_source_flag, 1);
    rst_flag_clr = 1;
    step(1);
    rst_flag_clr = 0;
    chk(mon1_reset_source_flag, 0);
    ctrl(1, 0, 1, 0, 1, 2'h0);
    flag(1, 0);
    chk(det2_level_status, 0);
    det2_enable = 1;
    watch(6);
    chk(det2_level_status, 1);
    ctrl(2, 0, 1, 1, 1, 2'h0);
    ctrl(2, 1, 1, 1, 1, 2'h0);
    chk({mon2_irq_reset_en, mon2_action_sel, mon2_direction_sel, det1_level_status}, 8'h0E);
    flag(2, 0);
    cmp2_above = 0;
    watch(12);
    chk(rst_seen, 1);
    chk({mon2_detect_flag, mon2_reset_source_flag}, 8'h03);
    cmp2_above = 1;
    watch(12);
    chk(rst_seen, 0);
    flag(2, 0);
    chk(mon2_detect_flag, 0);
    // Filtered, divide by 2; disable first, then let the filter settle
    ctrl(2, 0, 1, 1, 1, 2'h0);
    ctrl(2, 0, 0, 0, 1, 2'h1);
    watch(200);
    ctrl(2, 1, 0, 0, 1, 2'h1);
    flag(2, 0);
    chk({mon2_filter_off, mon2_sample_div_hi, mon2_sample_div_lo}, 8'h01);
    cmp2_above = 0;
    watch(120);
    chk(nmi_seen, 1);
    lowspeed_osc_stop = 1;
    cmp2_above = 1;
    watch(120);
    chk(nmi_seen, 0);
    lowspeed_osc_stop = 0;
    watch(120);
    chk(nmi_seen, 1);
    finish_test;
  end
endmodule // tb
